// ===== core/pcs_pkg.sv
// Constants and types shared by the clock synthesizer control block
// Summary of operation
// - Two references, exactly one active
// - Only dedicated or cascaded clocks count as references
// - Auto mode: switch when active reference vanishes
// - Manual mode: user logic selects the reference
// - At most five derived clock outputs
// - Only primary output drives external clock pin
// - Normal mode aligns register clock to input
// - Zero delay mode aligns external pin to input
// - Source synchronous keeps clock-to-data phase at pins
// - No compensation: no delay, lowest jitter
// - Run-time reload of divider and phase settings
// - Optional self reset when lock falls
// - Lock high only when locked and outputs valid
// - Phase detector off keeps current output frequency
package pcs_pkg;
   typedef enum logic [1:0] {PCS_NORMAL, PCS_ZERO_DELAY, PCS_SRC_SYNC, PCS_NO_COMP} pcs_mode_e;

   localparam int MCLK_MHZ = 25;
   // Reference counted absent after this long without a rising edge
   localparam int REF_LOSS_NS = 2000;
   localparam int REF_LOSS_CYCLES = (REF_LOSS_NS * MCLK_MHZ + 999) / 1000;
   // Self reset pulse length on loss of lock
   localparam int AUTO_RST_NS = 400;
   localparam int AUTO_RST_CYCLES = (AUTO_RST_NS * MCLK_MHZ + 999) / 1000;
   localparam int LOCK_EDGES = 8;
   localparam int N_REF = 2;
   localparam int N_OUT = 5;
   localparam int DIV_W = 8;

   localparam logic [3:0] TAPS_NORMAL = 4'h4;
   localparam logic [3:0] TAPS_ZERO_DELAY = 4'h6;
   localparam logic [3:0] TAPS_SRC_SYNC = 4'h2;
   localparam logic [3:0] TAPS_NONE = 4'h0;
   localparam logic [7:0] DIV_RESET = 8'h01;
   localparam logic [7:0] PHASE_RESET = 8'h00;
endpackage : pcs_pkg

// ===== core/pcs_ref_monitor.sv
// Reference clock synchroniser, edge detector and presence monitor
`timescale 1ns/10ps
module pcs_ref_monitor #(
   parameter int TIMEOUT = pcs_pkg::REF_LOSS_CYCLES
) (
   input wire logic i_mclk,
   input wire logic i_reset_n,
   input wire logic i_ref_pin,
   input wire logic i_dedicated,
   output logic o_edge,
   output logic o_present
);
   if (TIMEOUT < 4 || TIMEOUT > 65535)
   begin : g_bad_timeout
      $error("pcs_ref_monitor: TIMEOUT out of range");
   end

   logic sync1;
   logic sync2;
   logic sync3;
   logic [15:0] idle;

   always_ff @(posedge i_mclk)
   begin
      sync1 <= i_ref_pin;
      sync2 <= sync1;
      sync3 <= sync2;
   end

   // Only rising edges seen on a dedicated or cascaded source count
   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n)
      begin
         o_edge <= 1'b0;
         o_present <= 1'b0;
         idle <= 16'h0000;
      end
      else
      begin
         o_edge <= sync2 & ~sync3 & i_dedicated;
         if (!i_dedicated)
         begin
            o_present <= 1'b0;
            idle <= 16'h0000;
         end
         else if (sync2 & ~sync3)
         begin
            o_present <= 1'b1;
            idle <= 16'h0000;
         end
         else if (idle == 16'(TIMEOUT - 1))
            o_present <= 1'b0;
         else
            idle <= idle + 16'h0001;
      end
   end

   a_nondedicated_absent: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      !i_dedicated |=> !o_present && !o_edge) else $error("non-dedicated source seen");
endmodule : pcs_ref_monitor

// ===== core/pcs_core.sv
// Clock synthesizer control: reference select, lock, reset and output dividers
`timescale 1ns/10ps
module pcs_core #(
   parameter int LOCK_EDGES = pcs_pkg::LOCK_EDGES,
   parameter int AUTO_RST_CYCLES = pcs_pkg::AUTO_RST_CYCLES
) (
   input wire logic i_mclk,
   input wire logic i_reset_n,
   input wire logic [1:0] i_ref_pin,
   input wire logic [1:0] i_ref_dedicated,
   input wire logic i_areset_pin,
   input wire logic i_pfd_enable,
   input wire logic i_auto_switch_en,
   input wire logic i_manual_sel,
   input wire logic i_auto_reset_en,
   input wire pcs_pkg::pcs_mode_e i_mode,
   input wire logic i_reconfig_strobe,
   input wire logic [pcs_pkg::N_OUT-1:0][pcs_pkg::DIV_W-1:0] i_div_half,
   input wire logic [pcs_pkg::N_OUT-1:0][pcs_pkg::DIV_W-1:0] i_phase,
   output logic o_locked,
   output logic o_active_ref,
   output logic o_ref_present,
   output logic o_primary_clock_out,
   output logic o_secondary_clock_out_1,
   output logic o_secondary_clock_out_2,
   output logic o_secondary_clock_out_3,
   output logic o_secondary_clock_out_4,
   output logic o_ext_clk_pin,
   output logic [3:0] o_comp_taps
);
   localparam int NO = pcs_pkg::N_OUT;
   localparam int DW = pcs_pkg::DIV_W;

   if (LOCK_EDGES < 2 || LOCK_EDGES > 255)
   begin : g_bad_lock
      $error("pcs_core: LOCK_EDGES out of range");
   end
   // The self reset check below expects at least three cycles of loop reset
   if (AUTO_RST_CYCLES < 3 || AUTO_RST_CYCLES > 65535)
   begin : g_bad_rst
      $error("pcs_core: AUTO_RST_CYCLES out of range");
   end
   if (NO > 5 || pcs_pkg::N_REF != 2)
   begin : g_bad_size
      $error("pcs_core: unsupported size");
   end

   logic [1:0] ref_edge;
   logic [1:0] ref_present;
   logic areset_s1;
   logic areset_s2;
   logic pfd_s1;
   logic pfd_s2;
   logic active;
   logic switch_evt;
   logic locked;
   logic [7:0] edge_cnt;
   logic [15:0] auto_rst_cnt;
   logic running;
   logic pll_rst;
   logic act_edge;
   logic act_present;
   logic [NO-1:0] clk_q;
   logic [NO-1:0][DW-1:0] cnt;
   logic [NO-1:0][DW-1:0] half;
   logic [NO-1:0][DW-1:0] phase;

   for (genvar r = 0; r < 2; r++)
   begin : g_ref
      pcs_ref_monitor #(.TIMEOUT(pcs_pkg::REF_LOSS_CYCLES)) u_mon (
         .i_mclk(i_mclk),
         .i_reset_n(i_reset_n),
         .i_ref_pin(i_ref_pin[r]),
         .i_dedicated(i_ref_dedicated[r]),
         .o_edge(ref_edge[r]),
         .o_present(ref_present[r])
      );
   end

   // Reset and phase detector enable are board pins
   always_ff @(posedge i_mclk)
   begin
      areset_s1 <= i_areset_pin;
      areset_s2 <= areset_s1;
      pfd_s1 <= i_pfd_enable;
      pfd_s2 <= pfd_s1;
   end

   assign pll_rst = areset_s2 | (auto_rst_cnt != 16'h0000);
   assign act_edge = ref_edge[active];
   assign act_present = ref_present[active];

   // Exactly one reference active; an automatic switch only occurs to a present clock, a manual one does not check presence
   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n)
      begin
         active <= 1'b0;
         switch_evt <= 1'b0;
      end
      else
      begin
         switch_evt <= 1'b0;
         if (i_auto_switch_en)
         begin
            if (!act_present && ref_present[~active])
            begin
               active <= ~active;
               switch_evt <= 1'b1;
            end
         end
         else if (i_manual_sel != active)
         begin
            active <= i_manual_sel;
            switch_evt <= 1'b1;
         end
      end
   end

   // Lock needs an unbroken run of reference edges with the detector on
   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n || pll_rst || switch_evt || i_reconfig_strobe)
      begin
         locked <= 1'b0;
         edge_cnt <= 8'h00;
      end
      else if (pfd_s2 && !act_present)
      begin
         locked <= 1'b0;
         edge_cnt <= 8'h00;
      end
      else if (pfd_s2 && act_edge && !locked)
      begin
         if (edge_cnt == 8'(LOCK_EDGES - 1))
            locked <= 1'b1;
         else
            edge_cnt <= edge_cnt + 8'h01;
      end
   end

   // Self reset holds the loop down for a fixed time after lock falls
   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n)
         auto_rst_cnt <= 16'h0000;
      else if (auto_rst_cnt != 16'h0000)
         auto_rst_cnt <= auto_rst_cnt - 16'h0001;
      else if (i_auto_reset_en && o_locked && !locked && !areset_s2)
         auto_rst_cnt <= 16'(AUTO_RST_CYCLES);
   end

   // Once started, outputs free-run through reference loss while the phase detector is off: holdover
   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n || pll_rst)
         running <= 1'b0;
      else if (locked)
         running <= 1'b1;
      else if (pfd_s2 && !act_present)
         running <= 1'b0;
      else
         running <= running;
   end

   // Settings take effect at the strobe; lock is dropped so user logic sees the glitch
   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n)
      begin
         half <= {NO{pcs_pkg::DIV_RESET}};
         phase <= {NO{pcs_pkg::PHASE_RESET}};
      end
      else if (i_reconfig_strobe)
      begin
         half <= i_div_half;
         phase <= i_phase;
      end
   end

   for (genvar k = 0; k < NO; k++)
   begin : g_div
      logic [DW-1:0] top;
      assign top = (half[k] == '0) ? '0 : half[k] - 1'b1;
      always_ff @(posedge i_mclk)
      begin
         if (!i_reset_n || !running || (locked && !o_locked))
         begin
            clk_q[k] <= 1'b0;
            cnt[k] <= phase[k];
         end
         else if (cnt[k] == '0)
         begin
            clk_q[k] <= ~clk_q[k];
            cnt[k] <= top;
         end
         else
            cnt[k] <= cnt[k] - 1'b1;
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n)
         o_comp_taps <= pcs_pkg::TAPS_NONE;
      else
         case (i_mode)
            pcs_pkg::PCS_NORMAL: o_comp_taps <= pcs_pkg::TAPS_NORMAL;
            pcs_pkg::PCS_ZERO_DELAY: o_comp_taps <= pcs_pkg::TAPS_ZERO_DELAY;
            pcs_pkg::PCS_SRC_SYNC: o_comp_taps <= pcs_pkg::TAPS_SRC_SYNC;
            default: o_comp_taps <= pcs_pkg::TAPS_NONE;
         endcase
   end

   // Outputs registered once more; downstream must gate on lock
   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n)
      begin
         o_locked <= 1'b0;
         o_active_ref <= 1'b0;
         o_ref_present <= 1'b0;
         o_primary_clock_out <= 1'b0;
         o_secondary_clock_out_1 <= 1'b0;
         o_secondary_clock_out_2 <= 1'b0;
         o_secondary_clock_out_3 <= 1'b0;
         o_secondary_clock_out_4 <= 1'b0;
         o_ext_clk_pin <= 1'b0;
      end
      else
      begin
         o_locked <= locked;
         o_active_ref <= active;
         o_ref_present <= act_present;
         o_primary_clock_out <= clk_q[0];
         o_secondary_clock_out_1 <= clk_q[1];
         o_secondary_clock_out_2 <= clk_q[2];
         o_secondary_clock_out_3 <= clk_q[3];
         o_secondary_clock_out_4 <= clk_q[4];
         o_ext_clk_pin <= clk_q[0];
      end
   end

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_reset_n);

   a_auto_switch: assert property (i_auto_switch_en && !act_present
      && ref_present[~active] |=> active != $past(active))
      else $error("auto switchover missed");
   a_manual_follow: assert property (!i_auto_switch_en && i_manual_sel != active
      |=> active == $past(i_manual_sel)) else $error("manual select ignored");
   a_reset_unlock: assert property (pll_rst |=> !locked ##1 !o_locked)
      else $error("lock during reset");
   a_lock_count: assert property ($rose(locked) |-> $past(edge_cnt) == 8'(LOCK_EDGES - 1))
      else $error("lock before edge count");
   a_ext_primary: assert property (o_ext_clk_pin == o_primary_clock_out)
      else $error("external pin not primary");
   a_holdover: assert property (!pfd_s2 && running && !pll_rst && i_reset_n
      |=> running) else $error("holdover lost");
   a_self_reset: assert property (i_auto_reset_en && o_locked && !locked && !pll_rst
      |=> pll_rst [*3]) else $error("no self reset");
   a_no_comp: assert property ($past(i_mode) == pcs_pkg::PCS_NO_COMP
      |-> o_comp_taps == pcs_pkg::TAPS_NONE) else $error("compensation in no-comp mode");
   a_reconfig_unlock: assert property (i_reconfig_strobe |=> !locked ##1 !o_locked)
      else $error("lock kept over reconfig");

   c_lock: cover property ($rose(o_locked));
   c_auto_switch: cover property (i_auto_switch_en && switch_evt);
   c_holdover: cover property (!pfd_s2 && running && !act_present);
   c_reconfig: cover property (i_reconfig_strobe ##[1:200] $rose(o_locked));
endmodule : pcs_core

// ===== tb/pcs_ref_model.sv
// Reference clock source model for the two synthesizer inputs
`timescale 1ns/10ps
module pcs_ref_model #(
   parameter int HALF_NS = 200
) (
   input wire logic [1:0] i_run,
   output logic [1:0] o_ref
);
   // Two independent references, either one may be stopped
   // A stopped reference stands still low, as a dead oscillator would
   initial
   begin
      o_ref = 2'h0;
      forever
      begin
         #(HALF_NS);
         o_ref = ~o_ref & i_run;
      end
   end
endmodule : pcs_ref_model

// ===== tb/tb_pcs_core.sv
// Self-checking bench for the clock synthesizer control block
`timescale 1ns/10ps
module tb_pcs_core;
   logic i_mclk = 1'b0;
   logic i_reset_n = 1'b0;
   logic [1:0] ref_run = 2'h3;
   logic [1:0] ref_pin;
   logic [1:0] dedicated = 2'h3;
   logic areset = 1'b0;
   logic pfd = 1'b1;
   logic auto_sw = 1'b0;
   logic man_sel = 1'b0;
   pcs_pkg::pcs_mode_e mode = pcs_pkg::PCS_NORMAL;
   logic strobe = 1'b0;
   logic [pcs_pkg::N_OUT-1:0][pcs_pkg::DIV_W-1:0] div_half = '0;
   logic [pcs_pkg::N_OUT-1:0][pcs_pkg::DIV_W-1:0] phase = '0;
   logic locked, act, present, c0, c1, c2, c3, c4, ext;
   logic [3:0] taps;
   logic auto_rst = 1'b1;
   logic [3:0] exp_taps [4] = '{pcs_pkg::TAPS_NORMAL, pcs_pkg::TAPS_ZERO_DELAY,
      pcs_pkg::TAPS_SRC_SYNC, pcs_pkg::TAPS_NONE};
   int n_fail = 0;
   int checks = 0;
   int cnt;

   initial
   begin
      forever #20 i_mclk = ~i_mclk;
   end

   pcs_ref_model #(.HALF_NS(200)) u_ref (.i_run(ref_run), .o_ref(ref_pin));

   pcs_core #(.LOCK_EDGES(2), .AUTO_RST_CYCLES(10)) uut (
      .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_ref_pin(ref_pin),
      .i_ref_dedicated(dedicated), .i_areset_pin(areset), .i_pfd_enable(pfd),
      .i_auto_switch_en(auto_sw), .i_manual_sel(man_sel), .i_auto_reset_en(auto_rst),
      .i_mode(mode), .i_reconfig_strobe(strobe), .i_div_half(div_half),
      .i_phase(phase), .o_locked(locked), .o_active_ref(act), .o_ref_present(present),
      .o_primary_clock_out(c0), .o_secondary_clock_out_1(c1),
      .o_secondary_clock_out_2(c2), .o_secondary_clock_out_3(c3),
      .o_secondary_clock_out_4(c4), .o_ext_clk_pin(ext), .o_comp_taps(taps));

   task automatic report_and_stop;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : report_and_stop

   task automatic cyc(input int n);
      repeat (n) @(negedge i_mclk);
   endtask : cyc

   task automatic cmp1(input logic got, input logic exp);
      checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp1

   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp8

   // Derived clocks are trusted only once lock is seen
   task automatic wait_lock;
      cnt = 0;
      while (locked !== 1'b1 && cnt < 300)
      begin
         cyc(1);
         cnt++;
      end
      if (cnt >= 300)
      begin
         n_fail++;
         $display("BAD t=%0t got %h exp %h", $time, locked, 1'b1);
         report_and_stop();
      end
   endtask : wait_lock

   // High time of the primary output in mclk cycles, from a fresh rising edge
   task automatic high_time(output int n);
      cnt = 0;
      while (c0 === 1'b1 && cnt < 100)
      begin
         cyc(1);
         cnt++;
      end
      while (c0 !== 1'b1 && cnt < 100)
      begin
         cyc(1);
         cnt++;
      end
      if (cnt >= 100)
      begin
         n_fail++;
         $display("BAD t=%0t got %h exp %h", $time, c0, 1'b1);
         report_and_stop();
      end
      n = 0;
      while (c0 === 1'b1 && n < 100)
      begin
         cmp1(ext, c0);
         cyc(1);
         n++;
      end
   endtask : high_time

   initial
   begin
      int ht;
      logic [3:0] v;
      cyc(12);
      cmp1(locked, 1'b0);
      cmp1(act, 1'b0);
      i_reset_n = 1'b1;
      cyc(1);
      cmp1(locked, 1'b0);
      $display("test reset done");
      for (int m = 0; m < 4; m++)
      begin
         mode = pcs_pkg::pcs_mode_e'(m);
         cyc(2);
         cmp8({4'h0, taps}, {4'h0, exp_taps[m]});
      end
      $display("test modes done");
      wait_lock();
      cmp1(act, 1'b0);
      div_half[0] = 8'h03;
      strobe = 1'b1;
      cyc(1);
      strobe = 1'b0;
      cyc(2);
      cmp1(locked, 1'b0);
      // Self reset stops every divider while the loop is held down
      cyc(4);
      cmp1(c1, 1'b0);
      cyc(1);
      cmp1(c1, 1'b0);
      wait_lock();
      high_time(ht);
      cmp8(ht[7:0], 8'h03);
      // Secondary outputs, reloaded with a zero setting, toggle every cycle: one cycle per half period
      v = {c4, c3, c2, c1};
      cyc(1);
      cmp8({4'h0, c4, c3, c2, c1}, {4'h0, ~v});
      $display("test reconfig done");
      man_sel = 1'b1;
      cyc(3);
      cmp1(act, 1'b1);
      cmp1(locked, 1'b0);
      wait_lock();
      $display("test manual done");
      auto_sw = 1'b1;
      ref_run = 2'h1;
      cyc(80);
      cmp1(act, 1'b0);
      wait_lock();
      $display("test auto done");
      pfd = 1'b0;
      cyc(4);
      ref_run = 2'h0;
      cyc(90);
      cmp1(locked, 1'b1);
      cmp1(present, 1'b0);
      cmp1(act, 1'b0);
      high_time(ht);
      cmp8(ht[7:0], 8'h03);
      $display("test holdover done");
      pfd = 1'b1;
      ref_run = 2'h3;
      areset = 1'b1;
      cyc(6);
      cmp1(locked, 1'b0);
      areset = 1'b0;
      cyc(4);
      cmp1(locked, 1'b0);
      wait_lock();
      $display("test areset done");
      dedicated = 2'h2;
      auto_rst = 1'b0;
      cyc(5);
      cmp1(act, 1'b1);
      cmp1(present, 1'b1);
      // Without self reset the dividers keep running through the lock loss
      cyc(3);
      v = {c4, c3, c2, c1};
      cyc(1);
      cmp8({4'h0, c4, c3, c2, c1}, {4'h0, ~v});
      $display("test dedicated done");
      report_and_stop();
   end
endmodule : tb_pcs_core
